// file: hdl/pinirq_pkg.sv
/*
  package for the pin interrupt unit: register offsets, field positions,
  reset values. assumes an apb slave with 32-bit data, byte addresses.
*/
package pinirq_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PINIRQ_OFS_SC     = 8'h00;
  localparam logic [7:0] PINIRQ_OFS_PE     = 8'h04;
  localparam logic [7:0] PINIRQ_OFS_ES     = 8'h08;
  localparam logic [7:0] PINIRQ_OFS_PULL   = 8'h0c;
  localparam logic [7:0] PINIRQ_OFS_STOP   = 8'h10;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int PINIRQ_SC_MOD = 0;
  localparam int PINIRQ_SC_IE  = 1;
  localparam int PINIRQ_SC_ACK = 2;
  localparam int PINIRQ_SC_FLG = 3;
  localparam int PINIRQ_NPINS  = 8;
  localparam logic [7:0] PINIRQ_RST_BYTE = 8'h00;
endpackage

// file: hdl/pinirq_unit.sv
/*
  eight-pin interrupt unit with an apb register slave.
  assumes pins are synchronous to pclk; stop_deep_i is a level from the
  power controller, high while the deepest stop modes are active.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module pinirq_unit
  import pinirq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  irq_input_pin,
  input  wire logic        stop_deep_i,
  output logic             irq_o,
  output logic [7:0]       pull_up_en_o,
  output logic [7:0]       pull_dn_en_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic       detect_mode_q, irq_enable_q, detect_flag_q;
  logic [7:0] pin_irq_enable_mask_q, pin_irq_polarity_select_q;
  logic [7:0] port_pull_enable_q;
  logic [7:0] asserted_q;
  logic       armed_q;
  logic       detect_mode_d, irq_enable_d, detect_flag_d, armed_d;
  logic [7:0] pe_d, es_d, pull_d;
  logic [31:0] prdata_d;
  logic       pslverr_d;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_sc   = paddr == PINIRQ_OFS_SC;
  wire hit_pe   = paddr == PINIRQ_OFS_PE;
  wire hit_es   = paddr == PINIRQ_OFS_ES;
  wire hit_pull = paddr == PINIRQ_OFS_PULL;
  wire hit_stop = paddr == PINIRQ_OFS_STOP;
  wire mapped   = hit_sc | hit_pe | hit_es | hit_pull | hit_stop;
  wire wr_sc    = wr & hit_sc & ~stop_deep_i;
  wire ack_wr   = wr_sc & pwdata[PINIRQ_SC_ACK];
  // low write byte, kept as a net so the checks can look back at it
  wire [7:0] wbyte = pwdata[7:0];

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  // asserted level per pin after polarity, masked by enable
  wire [7:0] pol_in  = irq_input_pin ^ ~pin_irq_polarity_select_q;
  wire [7:0] act     = pol_in & pin_irq_enable_mask_q;
  // edge: deasserted last cycle, asserted now
  wire [7:0] edges   = act & ~asserted_q;
  wire       any_act = |act;
  wire       edge_ok = armed_q & |edges;
  wire       set_flg = edge_ok | (detect_mode_q & any_act);
  wire       clr_ok  = ack_wr & ~(detect_mode_q & any_act);

  always_comb begin
    detect_mode_d = detect_mode_q;
    irq_enable_d  = irq_enable_q;
    pe_d          = pin_irq_enable_mask_q;
    es_d          = pin_irq_polarity_select_q;
    pull_d        = port_pull_enable_q;
    if (wr_sc) begin
      detect_mode_d = pwdata[PINIRQ_SC_MOD];
      irq_enable_d  = pwdata[PINIRQ_SC_IE];
    end
    if (wr & hit_pe & ~stop_deep_i) begin
      pe_d = pwdata[7:0];
    end
    if (wr & hit_es & ~stop_deep_i) begin
      es_d = pwdata[7:0];
    end
    if (wr & hit_pull & ~stop_deep_i) begin
      pull_d = pwdata[7:0];
    end
    // set wins over acknowledge in the same cycle
    detect_flag_d = set_flg | (detect_flag_q & ~clr_ok);
    // re-arm only once every enabled input is back at rest
    armed_d = ~any_act | (armed_q & ~|edges);
    if (stop_deep_i) begin
      detect_mode_d = 1'b0;
      irq_enable_d  = 1'b0;
      pe_d          = PINIRQ_RST_BYTE;
      es_d          = PINIRQ_RST_BYTE;
      pull_d        = PINIRQ_RST_BYTE;
      detect_flag_d = 1'b0;
      armed_d       = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] sc_rd = {4'h0, detect_flag_q, 1'b0, irq_enable_q,
                      detect_mode_q};
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      if (hit_sc)   prdata_d = {24'h00_0000, sc_rd};
      if (hit_pe)   prdata_d = {24'h00_0000, pin_irq_enable_mask_q};
      if (hit_es)   prdata_d = {24'h00_0000, pin_irq_polarity_select_q};
      if (hit_pull) prdata_d = {24'h00_0000, port_pull_enable_q};
      if (hit_stop) prdata_d = {31'h0, stop_deep_i};
    end else if (acc) begin
      prdata_d = prdata;
    end
  end
  // unmapped address errors; slave answers in the first access cycle
  assign pslverr_d = psel & ~penable & ~mapped;

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_mode_q             <= 1'b0;
      irq_enable_q              <= 1'b0;
      detect_flag_q             <= 1'b0;
      pin_irq_enable_mask_q     <= PINIRQ_RST_BYTE;
      pin_irq_polarity_select_q <= PINIRQ_RST_BYTE;
      port_pull_enable_q        <= PINIRQ_RST_BYTE;
      asserted_q                <= 8'h00;
      armed_q                   <= 1'b0;
      irq_o                     <= 1'b0;
      pull_up_en_o              <= 8'h00;
      pull_dn_en_o              <= 8'h00;
      pready                    <= 1'b1;
      prdata                    <= 32'h0000_0000;
      pslverr                   <= 1'b0;
    end else begin
      detect_mode_q             <= detect_mode_d;
      irq_enable_q              <= irq_enable_d;
      detect_flag_q             <= detect_flag_d;
      pin_irq_enable_mask_q     <= pe_d;
      pin_irq_polarity_select_q <= es_d;
      port_pull_enable_q        <= pull_d;
      asserted_q                <= stop_deep_i ? 8'h00 : act;
      armed_q                   <= armed_d;
      irq_o                     <= detect_flag_d & irq_enable_d;
      pull_up_en_o              <= pull_d & ~es_d;
      pull_dn_en_o              <= pull_d & es_d;
      pready                    <= 1'b1;
      prdata                    <= prdata_d;
      pslverr                   <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  upper_zero_a: assert property (
    psel && penable && !pwrite && paddr == PINIRQ_OFS_SC |->
      prdata[7:4] == 4'h0 && prdata[2] == 1'b0)
    else $error("status upper bits or ack read nonzero");
  flag_ro_a: assert property (
    !detect_flag_q && !set_flg |=> !detect_flag_q)
    else $error("flag set without detection");
  irq_follow_a: assert property (
    ##1 irq_o == $past(detect_flag_d && irq_enable_d))
    else $error("irq output mismatch");
  irq_off_a: assert property (
    !irq_enable_q && !wr_sc |=> !irq_o)
    else $error("irq raised while disabled");
  edge_set_a: assert property (
    armed_q && |edges && !stop_deep_i |=> detect_flag_q)
    else $error("edge did not set flag");
  masked_pin_a: assert property (
    pin_irq_enable_mask_q == 8'h00 |-> act == 8'h00)
    else $error("disabled pin seen");
  level_hold_a: assert property (
    detect_mode_q && any_act && ack_wr && !stop_deep_i
      |=> detect_flag_q)
    else $error("flag cleared while level asserted");
  ack_clear_a: assert property (
    ack_wr && !set_flg && !(detect_mode_q && any_act) && !stop_deep_i
      |=> !detect_flag_q)
    else $error("ack did not clear flag");
  rearm_a: assert property (
    |edges && armed_q && any_act |=> !armed_q)
    else $error("not disarmed after edge");
  deep_stop_a: assert property (
    stop_deep_i |=> !detect_flag_q && pin_irq_enable_mask_q == 8'h00)
    else $error("deep stop did not reset");
  pull_dir_a: assert property (
    ##1 (pull_up_en_o & pull_dn_en_o) == 8'h00)
    else $error("pull up and down both on");

  // ----------------------------------------------------------------
  // register write checks
  // ----------------------------------------------------------------
  ctl_write_a: assert property (
    wr_sc |=> {6'h00, irq_enable_q, detect_mode_q} == ($past(wbyte) & 8'h03))
    else $error("control bits not written");

  pe_write_a: assert property (
    wr && hit_pe && !stop_deep_i |=> pin_irq_enable_mask_q == $past(wbyte))
    else $error("pin enable not written");

  pe_hold_a: assert property (
    !(wr && hit_pe) && !stop_deep_i |=> $stable(pin_irq_enable_mask_q))
    else $error("pin enable changed without write");

  es_write_a: assert property (
    wr && hit_es && !stop_deep_i
      |=> pin_irq_polarity_select_q == $past(wbyte))
    else $error("polarity not written");

  es_hold_a: assert property (
    !(wr && hit_es) && !stop_deep_i |=> $stable(pin_irq_polarity_select_q))
    else $error("polarity changed without write");

  pull_write_a: assert property (
    wr && hit_pull && !stop_deep_i |=> port_pull_enable_q == $past(wbyte))
    else $error("pull enable not written");

  flag_wr_a: assert property (
    wr_sc && !set_flg && !detect_flag_q |=> !detect_flag_q)
    else $error("write changed flag");

  // ----------------------------------------------------------------
  // detection checks
  // ----------------------------------------------------------------
  level_set_a: assert property (
    detect_mode_q && any_act && !stop_deep_i |=> detect_flag_q)
    else $error("asserted level did not set flag");

  edge_only_a: assert property (
    !detect_mode_q && !edge_ok && !detect_flag_q |=> !detect_flag_q)
    else $error("flag set without edge");

  flag_keep_a: assert property (
    detect_flag_q && !ack_wr && !stop_deep_i |=> detect_flag_q)
    else $error("flag lost without acknowledge");

  level_clear_a: assert property (
    detect_mode_q && !any_act && ack_wr && !stop_deep_i |=> !detect_flag_q)
    else $error("level mode ack did not clear");

  mask_quiet_a: assert property (
    pin_irq_enable_mask_q == 8'h00 && !detect_flag_q |=> !detect_flag_q)
    else $error("flag set with all pins disabled");

  track_a: assert property (
    !stop_deep_i |=> asserted_q == $past(act))
    else $error("pin history not tracked");

  arm_rest_a: assert property (
    !any_act && !stop_deep_i |=> armed_q)
    else $error("not armed with inputs at rest");

  stay_off_a: assert property (
    !armed_q && any_act |=> !armed_q)
    else $error("rearmed while input asserted");

  irq_on_a: assert property (
    detect_flag_d && irq_enable_d |=> irq_o)
    else $error("request missing");

  irq_noflag_a: assert property (
    !detect_flag_d |=> !irq_o)
    else $error("request without flag");

  irq_noen_a: assert property (
    !irq_enable_d |=> !irq_o)
    else $error("request while disabled");

  pull_up_a: assert property (
    pull_up_en_o == (port_pull_enable_q & ~pin_irq_polarity_select_q))
    else $error("pull-up select wrong");

  pull_dn_a: assert property (
    pull_dn_en_o == (port_pull_enable_q & pin_irq_polarity_select_q))
    else $error("pull-down select wrong");

  // ----------------------------------------------------------------
  // deep stop checks
  // ----------------------------------------------------------------
  stop_ctl_a: assert property (
    stop_deep_i |=> !irq_enable_q && !detect_mode_q
      && pin_irq_polarity_select_q == 8'h00)
    else $error("control not reset in stop");

  stop_pull_a: assert property (
    stop_deep_i |=> port_pull_enable_q == 8'h00)
    else $error("pull enable not reset in stop");

  stop_arm_a: assert property (
    stop_deep_i |=> !armed_q && asserted_q == 8'h00)
    else $error("detection not reset in stop");

  stop_irq_a: assert property (
    stop_deep_i |=> !irq_o)
    else $error("request during stop");

  // ----------------------------------------------------------------
  // read path checks
  // ----------------------------------------------------------------
  // read data is latched at the setup edge, so it lags by one cycle
  read_sc_a: assert property (
    psel && !penable && !pwrite && hit_sc
      |=> prdata == {24'h00_0000, $past(sc_rd)})
    else $error("status read wrong");

  read_pe_a: assert property (
    psel && !penable && !pwrite && hit_pe
      |=> prdata == {24'h00_0000, $past(pin_irq_enable_mask_q)})
    else $error("pin enable read wrong");

  read_es_a: assert property (
    psel && !penable && !pwrite && hit_es
      |=> prdata == {24'h00_0000, $past(pin_irq_polarity_select_q)})
    else $error("polarity read wrong");

  read_pull_a: assert property (
    psel && !penable && !pwrite && hit_pull
      |=> prdata == {24'h00_0000, $past(port_pull_enable_q)})
    else $error("pull enable read wrong");

  rdata_hold_a: assert property (
    psel && penable |=> $stable(prdata))
    else $error("read data moved in access");

  err_map_a: assert property (
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not flagged");

  err_ok_a: assert property (
    psel && !penable && mapped |=> !pslverr)
    else $error("mapped access flagged");

  ready_a: assert property (
    pready)
    else $error("wait state inserted");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------

  edge_cov_c:  cover property (edge_ok ##1 detect_flag_q);
  level_cov_c: cover property (detect_mode_q && any_act && ack_wr);
  clear_cov_c: cover property (detect_flag_q ##1 !detect_flag_q);
  irq_cov_c:   cover property (irq_o);
  stop_cov_c:  cover property (stop_deep_i ##1 !stop_deep_i);
endmodule

// file: verif/pinirq_keys.sv
/*
  key matrix model for the pin interrupt unit.
  assumes the bench says which keys are held and their asserted levels.
*/
`timescale 1ns/10ps
module pinirq_keys (
  input  wire logic [7:0] press,
  input  wire logic [7:0] pol,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_dn,
  output logic      [7:0] pins
);
  // held key shorts to the asserted level; a free pin follows its pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (press[i]) pins[i] = pol[i];
      else if (pull_up[i]) pins[i] = 1'b1;
      else if (pull_dn[i]) pins[i] = 1'b0;
      else pins[i] = ~pol[i];
    end
  end
endmodule

// file: verif/tb_top.sv
/*
  self-checking bench for the pin interrupt unit.
  waits on pready for any wait count of the apb slave; assumes the key model on the pins.
*/
`timescale 1ns/10ps
module tb_top
  import pinirq_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, stop, pready;
  logic        pslverr, irq, err;
  logic [7:0]  paddr, press, pol, pins, pu, pd;
  logic [31:0] pwdata, prdata, rdat;
  int          mismatches, tests_run;

  pinirq_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq_input_pin(pins), .stop_deep_i(stop), .irq_o(irq),
    .pull_up_en_o(pu), .pull_dn_en_o(pd));
  pinirq_keys u_keys (.press(press), .pol(pol), .pull_up(pu),
    .pull_dn(pd), .pins(pins));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count is assumed; the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic keys(input logic [7:0] k);
    @(posedge pclk);
    press <= k;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_reset;
    rd(PINIRQ_OFS_SC, 32'h0);
    rd(PINIRQ_OFS_PE, 32'h0);
    rd(PINIRQ_OFS_ES, 32'h0);
    apb(1'b1, PINIRQ_OFS_SC, 32'h08);
    rd(PINIRQ_OFS_SC, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_edge;
    apb(1'b1, PINIRQ_OFS_SC, 32'h0);
    apb(1'b1, PINIRQ_OFS_ES, 32'h0);
    apb(1'b1, PINIRQ_OFS_PULL, 32'hff);
    apb(1'b1, PINIRQ_OFS_PE, 32'h01);
    apb(1'b1, PINIRQ_OFS_SC, 32'h04);
    apb(1'b1, PINIRQ_OFS_SC, 32'h02);
    chk({pd, pu}, 16'h00ff);
    rd(PINIRQ_OFS_PULL, 32'hff);
    rd(PINIRQ_OFS_SC, 32'h02);
    keys(8'h01);
    chk(irq, 1'b1);
    apb(1'b1, PINIRQ_OFS_SC, 32'hf2);
    rd(PINIRQ_OFS_SC, 32'h0a);
    apb(1'b1, PINIRQ_OFS_SC, 32'h06);
    rd(PINIRQ_OFS_SC, 32'h02);
    apb(1'b1, PINIRQ_OFS_PE, 32'h03);
    keys(8'h03);
    rd(PINIRQ_OFS_SC, 32'h02);
    keys(8'h00);
    keys(8'h02);
    rd(PINIRQ_OFS_SC, 32'h0a);
    keys(8'h00);
    apb(1'b1, PINIRQ_OFS_SC, 32'h06);
    keys(8'h80);
    rd(PINIRQ_OFS_SC, 32'h02);
    keys(8'h00);
    $display("test edge done");
  endtask

  task automatic t_level;
    apb(1'b1, PINIRQ_OFS_SC, 32'h0);
    pol <= 8'hff;
    apb(1'b1, PINIRQ_OFS_ES, 32'hff);
    apb(1'b1, PINIRQ_OFS_PE, 32'h04);
    apb(1'b1, PINIRQ_OFS_SC, 32'h05);
    apb(1'b1, PINIRQ_OFS_SC, 32'h03);
    chk({pd, pu}, 16'hff00);
    keys(8'h04);
    rd(PINIRQ_OFS_SC, 32'h0b);
    apb(1'b1, PINIRQ_OFS_SC, 32'h07);
    rd(PINIRQ_OFS_SC, 32'h0b);
    keys(8'h00);
    apb(1'b1, PINIRQ_OFS_SC, 32'h07);
    rd(PINIRQ_OFS_SC, 32'h03);
    apb(1'b1, PINIRQ_OFS_SC, 32'h01);
    keys(8'h04);
    chk(irq, 1'b0);
    rd(PINIRQ_OFS_SC, 32'h09);
    $display("test level done");
  endtask

  task automatic t_stop;
    @(posedge pclk);
    stop <= 1'b1;
    apb(1'b1, PINIRQ_OFS_PE, 32'hff);
    rd(PINIRQ_OFS_STOP, 32'h1);
    @(posedge pclk);
    stop <= 1'b0;
    rd(PINIRQ_OFS_SC, 32'h0);
    rd(PINIRQ_OFS_PE, 32'h0);
    rd(PINIRQ_OFS_ES, 32'h0);
    chk(irq, 1'b0);
    $display("test stop done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #500us;
    mismatches++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    stop = 1'b0;
    press = 8'h0;
    pol = 8'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edge();
    t_level();
    t_stop();
    print_verdict();
  end
endmodule
